// >>> core/sdtp_pkg.sv
// Package with offsets, field positions and defaults of the shutdown/threshold/protect slice
package sdtp_pkg;
    // Table numbers
    localparam logic [7:0] TBL_MAIN_01     = 8'h01;
    localparam logic [7:0] TBL_MAIN_02     = 8'h02;
    localparam logic [7:0] TBL_MAIN_03     = 8'h03;
    localparam logic [7:0] TBL_CFG         = 8'h04;
    localparam logic [7:0] TBL_DEV         = 8'h05;
    // Table 04h offsets
    localparam logic [7:0] OFS_SHUTDOWN_CONFIG = 8'hda;
    localparam logic [7:0] OFS_TX_POWER_HIGH   = 8'hdb;
    localparam logic [7:0] OFS_TX_POWER_LOW    = 8'hdc;
    localparam logic [7:0] OFS_RX_LOSS         = 8'hdd;
    // Table 05h offsets
    localparam logic [7:0] OFS_PART_ID_HI      = 8'hc0;
    localparam logic [7:0] OFS_PART_ID_LO      = 8'hc1;
    localparam logic [7:0] OFS_DESIGN_REV      = 8'hc2;
    localparam logic [7:0] OFS_L1_WP_ENABLE    = 8'hd1;
    localparam logic [7:0] OFS_L1_PW_B3        = 8'hd3;
    localparam logic [7:0] OFS_L1_PW_B2        = 8'hd4;
    localparam logic [7:0] OFS_L1_PW_B1        = 8'hd5;
    localparam logic [7:0] OFS_L1_PW_B0        = 8'hd6;
    // Protected region bounds
    localparam logic [7:0] RGN_DEV_LO_START    = 8'hd0;
    localparam logic [7:0] RGN_DEV_LO_END      = 8'hd6;
    localparam logic [7:0] RGN_MASK_START      = 8'hf8;
    localparam logic [7:0] RGN_MASK_END        = 8'hff;
    localparam logic [7:0] RGN_CFG_START       = 8'h80;
    localparam logic [7:0] RGN_CFG_END         = 8'hc7;
    localparam logic [7:0] RGN_USER_START      = 8'h80;
    localparam logic [7:0] RGN_USER_END        = 8'hf7;
    localparam logic [7:0] RGN_LOWER_END       = 8'h7a;
    localparam logic [7:0] RGN_AUX_UPPER_START = 8'h80;
    // Shutdown configuration fields
    localparam int SHD_POLARITY_BIT  = 7;
    localparam int SHD_TXP_HIGH_BIT  = 6;
    localparam int SHD_BIAS_HIGH_BIT = 5;
    localparam int SHD_TXP_LOW_BIT   = 4;
    localparam int SHD_MASK_SEL_BIT  = 0;
    // Write-protect enable fields
    localparam int WP_DEV_LO_BIT   = 7;
    localparam int WP_DEV_MASK_BIT = 6;
    localparam int WP_CFG_BIT      = 5;
    localparam int WP_USER_MASK_BIT = 4;
    localparam int WP_USER_BIT     = 3;
    localparam int WP_LOWER_BIT    = 2;
    localparam int WP_AUX_HI_BIT   = 1;
    localparam int WP_AUX_LO_BIT   = 0;
    // Factory defaults
    localparam logic [7:0]  RST_SHUTDOWN_CONFIG = 8'h00;
    localparam logic [7:0]  RST_TX_POWER_HIGH   = 8'hff;
    localparam logic [7:0]  RST_TX_POWER_LOW    = 8'h00;
    localparam logic [7:0]  RST_RX_LOSS         = 8'h00;
    localparam logic [7:0]  RST_L1_WP_ENABLE    = 8'h00;
    localparam logic [31:0] RST_L1_PASSWORD     = 32'h0000_0000;
    localparam logic [7:0]  RD_UNMAPPED         = 8'h00;
endpackage : sdtp_pkg

// >>> core/sdtp_regs.sv
// Shutdown configuration, threshold, identity and first-level write-protect register slice
`timescale 1ns/100ps
`default_nettype none
module sdtp_regs #(
    parameter logic [15:0] PART_ID    = 16'h5a5a,
    parameter logic [7:0]  DESIGN_REV = 8'h01
) (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_aux_sel,
    input  wire logic [7:0]  i_table,
    input  wire logic [7:0]  i_addr,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [31:0] i_entered_password,
    input  wire logic        i_nv_load,
    input  wire logic [15:0] i_tx_power,
    input  wire logic [15:0] i_rssi,
    input  wire logic        i_bias_high_trip,
    output logic [7:0]       o_rdata,
    output logic             o_rvalid,
    output logic             o_wr_blocked,
    output logic             o_laser_off_drive,
    output logic             o_mask_select,
    output logic             o_tx_power_high_trip,
    output logic             o_tx_power_low_trip,
    output logic             o_rx_loss_trip,
    output logic [7:0]       o_tx_power_high_limit,
    output logic [7:0]       o_tx_power_low_limit,
    output logic [7:0]       o_rx_loss_limit
);
    // Which protect-enable bit covers an address, one-hot or zero
    function automatic logic [7:0] sdtp_region(input logic aux, input logic [7:0] tbl,
                                               input logic [7:0] adr);
        logic [7:0] r;
        r = 8'h00;
        if (aux) begin
            r[sdtp_pkg::WP_AUX_HI_BIT] = (adr >= sdtp_pkg::RGN_AUX_UPPER_START);
            r[sdtp_pkg::WP_AUX_LO_BIT] = (adr < sdtp_pkg::RGN_AUX_UPPER_START);
        end else if (adr <= sdtp_pkg::RGN_LOWER_END) begin
            r[sdtp_pkg::WP_LOWER_BIT] = 1'b1;
        end else if (tbl == sdtp_pkg::TBL_DEV) begin
            r[sdtp_pkg::WP_DEV_LO_BIT] = (adr >= sdtp_pkg::RGN_DEV_LO_START) &&
                                         (adr <= sdtp_pkg::RGN_DEV_LO_END);
            r[sdtp_pkg::WP_DEV_MASK_BIT] = (adr >= sdtp_pkg::RGN_MASK_START);
        end else if (tbl == sdtp_pkg::TBL_MAIN_01) begin
            r[sdtp_pkg::WP_USER_MASK_BIT] = (adr >= sdtp_pkg::RGN_MASK_START);
            r[sdtp_pkg::WP_USER_BIT] = (adr >= sdtp_pkg::RGN_USER_START) &&
                                       (adr <= sdtp_pkg::RGN_USER_END);
        end else if ((tbl == sdtp_pkg::TBL_CFG) || (tbl == sdtp_pkg::TBL_MAIN_02) ||
                     (tbl == sdtp_pkg::TBL_MAIN_03)) begin
            r[sdtp_pkg::WP_CFG_BIT] = (adr >= sdtp_pkg::RGN_CFG_START) &&
                                      (adr <= sdtp_pkg::RGN_CFG_END);
        end
        return r;
    endfunction : sdtp_region

    // True when a main-memory access lands on one given byte of one table
    function automatic logic sdtp_hit(input logic aux, input logic [7:0] tbl,
                                      input logic [7:0] adr, input logic [7:0] want_tbl,
                                      input logic [7:0] want_ofs);
        return !aux && (tbl == want_tbl) && (adr == want_ofs);
    endfunction : sdtp_hit

    // Stored bytes
    logic [7:0]  shutdown_config_q;
    logic [7:0]  wp_enable_q;
    logic [7:0]  password_q [4];

    // Access decode
    logic [7:0]  region;
    logic [7:0]  shielded;
    logic        password_ok;
    logic        wr_blocked;
    logic        wr_accept;
    logic        hit_cfg;
    logic        hit_dev;
    logic        wr_shutdown;
    logic        wr_tx_high;
    logic        wr_tx_low;
    logic        wr_rx_loss;
    logic        wr_wp_enable;
    logic [3:0]  wr_pw_byte;
    logic [7:0]  rd_mux;

    // Shutdown path
    logic [7:0]  tx_upper;
    logic [7:0]  rssi_upper;
    logic        shutdown_cause;
    logic        txp_high_trip;
    logic        txp_low_trip;
    logic        rx_low_trip;
    logic        laser_off_d;

    // Protect bits that cover the addressed byte
    assign region = sdtp_region(i_aux_sel, i_table, i_addr);
    for (genvar b = 0; b < 8; b++) begin : g_shield
        assign shielded[b] = region[b] && wp_enable_q[b];
    end : g_shield

    assign password_ok = (i_entered_password == {password_q[0], password_q[1],
                                                  password_q[2], password_q[3]});
    assign wr_blocked  = (|shielded) && !password_ok;
    // Power-up shadow loads bypass protection
    assign wr_accept   = i_nv_load || (i_wr_en && !wr_blocked);
    assign hit_cfg     = !i_aux_sel && (i_table == sdtp_pkg::TBL_CFG);
    assign hit_dev     = !i_aux_sel && (i_table == sdtp_pkg::TBL_DEV);

    // One write strobe per stored byte
    assign wr_shutdown  = wr_accept && sdtp_hit(i_aux_sel, i_table, i_addr,
        sdtp_pkg::TBL_CFG, sdtp_pkg::OFS_SHUTDOWN_CONFIG);
    assign wr_tx_high   = wr_accept && sdtp_hit(i_aux_sel, i_table, i_addr,
        sdtp_pkg::TBL_CFG, sdtp_pkg::OFS_TX_POWER_HIGH);
    assign wr_tx_low    = wr_accept && sdtp_hit(i_aux_sel, i_table, i_addr,
        sdtp_pkg::TBL_CFG, sdtp_pkg::OFS_TX_POWER_LOW);
    assign wr_rx_loss   = wr_accept && sdtp_hit(i_aux_sel, i_table, i_addr,
        sdtp_pkg::TBL_CFG, sdtp_pkg::OFS_RX_LOSS);
    assign wr_wp_enable = wr_accept && sdtp_hit(i_aux_sel, i_table, i_addr,
        sdtp_pkg::TBL_DEV, sdtp_pkg::OFS_L1_WP_ENABLE);

    // Shutdown configuration byte; bits 3 to 1 are kept but drive nothing
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shutdown_config_q <= sdtp_pkg::RST_SHUTDOWN_CONFIG;
        end else if (wr_shutdown) begin
            shutdown_config_q <= i_wdata;
        end
    end

    // Mask-location bit leaves as its own output for the interrupt logic
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mask_select <= sdtp_pkg::RST_SHUTDOWN_CONFIG[sdtp_pkg::SHD_MASK_SEL_BIT];
        end else if (wr_shutdown) begin
            o_mask_select <= i_wdata[sdtp_pkg::SHD_MASK_SEL_BIT];
        end
    end

    // High transmit-power limit
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_power_high_limit <= sdtp_pkg::RST_TX_POWER_HIGH;
        end else if (wr_tx_high) begin
            o_tx_power_high_limit <= i_wdata;
        end
    end

    // Low transmit-power limit
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_power_low_limit <= sdtp_pkg::RST_TX_POWER_LOW;
        end else if (wr_tx_low) begin
            o_tx_power_low_limit <= i_wdata;
        end
    end

    // Receive-loss limit
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx_loss_limit <= sdtp_pkg::RST_RX_LOSS;
        end else if (wr_rx_loss) begin
            o_rx_loss_limit <= i_wdata;
        end
    end

    // First-level protect enables; the byte guards itself through bit 7
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp_enable_q <= sdtp_pkg::RST_L1_WP_ENABLE;
        end else if (wr_wp_enable) begin
            wp_enable_q <= i_wdata;
        end
    end

    // Password bytes, most significant at the lowest offset
    for (genvar g = 0; g < 4; g++) begin : g_pw_byte
        assign wr_pw_byte[g] = wr_accept &&
            sdtp_hit(i_aux_sel, i_table, i_addr, sdtp_pkg::TBL_DEV,
                     sdtp_pkg::OFS_L1_PW_B3 + 8'(g));
        always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                password_q[g] <= sdtp_pkg::RST_L1_PASSWORD[31 - 8 * g -: 8];
            end else if (wr_pw_byte[g]) begin
                password_q[g] <= i_wdata;
            end
        end
    end : g_pw_byte

    // Read data; the password itself reads back as zero
    always_comb begin
        rd_mux = sdtp_pkg::RD_UNMAPPED;
        if (hit_cfg) begin
            unique case (i_addr)
                sdtp_pkg::OFS_SHUTDOWN_CONFIG: rd_mux = shutdown_config_q;
                sdtp_pkg::OFS_TX_POWER_HIGH:   rd_mux = o_tx_power_high_limit;
                sdtp_pkg::OFS_TX_POWER_LOW:    rd_mux = o_tx_power_low_limit;
                sdtp_pkg::OFS_RX_LOSS:         rd_mux = o_rx_loss_limit;
                default:                       rd_mux = sdtp_pkg::RD_UNMAPPED;
            endcase
        end else if (hit_dev) begin
            unique case (i_addr)
                sdtp_pkg::OFS_PART_ID_HI:   rd_mux = PART_ID[15:8];
                sdtp_pkg::OFS_PART_ID_LO:   rd_mux = PART_ID[7:0];
                sdtp_pkg::OFS_DESIGN_REV:   rd_mux = DESIGN_REV;
                sdtp_pkg::OFS_L1_WP_ENABLE: rd_mux = wp_enable_q;
                default:                    rd_mux = sdtp_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // Read data holds until the next read
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= sdtp_pkg::RD_UNMAPPED;
        end else if (i_rd_en) begin
            o_rdata <= rd_mux;
        end
    end

    // Read valid is a one-cycle pulse behind the request
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
        end
    end

    // A refused write is flagged for one cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr_blocked <= 1'b0;
        end else begin
            o_wr_blocked <= i_wr_en && wr_blocked;
        end
    end

    // Fast-trip comparisons look at the upper measurement byte only
    assign tx_upper       = i_tx_power[15:8];
    assign rssi_upper     = i_rssi[15:8];
    assign txp_high_trip  = (tx_upper > o_tx_power_high_limit);
    assign txp_low_trip   = (tx_upper < o_tx_power_low_limit);
    assign rx_low_trip    = (rssi_upper < o_rx_loss_limit);
    assign shutdown_cause =
        (shutdown_config_q[sdtp_pkg::SHD_TXP_HIGH_BIT]  && txp_high_trip)    ||
        (shutdown_config_q[sdtp_pkg::SHD_BIAS_HIGH_BIT] && i_bias_high_trip) ||
        (shutdown_config_q[sdtp_pkg::SHD_TXP_LOW_BIT]   && txp_low_trip);
    // Shutdown drives the polarity value, idle drives its inverse
    assign laser_off_d    = shutdown_cause ~^
                            shutdown_config_q[sdtp_pkg::SHD_POLARITY_BIT];

    // Laser-off resets to the idle level, the inverse of the reset polarity
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_laser_off_drive <= ~sdtp_pkg::RST_SHUTDOWN_CONFIG[sdtp_pkg::SHD_POLARITY_BIT];
        end else begin
            o_laser_off_drive <= laser_off_d;
        end
    end

    // Transmit-power-high alarm level
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_power_high_trip <= 1'b0;
        end else begin
            o_tx_power_high_trip <= txp_high_trip;
        end
    end

    // Transmit-power-low alarm level
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_power_low_trip <= 1'b0;
        end else begin
            o_tx_power_low_trip <= txp_low_trip;
        end
    end

    // Receive-loss alarm level
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx_loss_trip <= 1'b0;
        end else begin
            o_rx_loss_trip <= rx_low_trip;
        end
    end
endmodule : sdtp_regs
`default_nettype wire

// >>> verification/sdtp_regs_assertions.sv
// Port-level checks of the register slice
`timescale 1ns/100ps
`default_nettype none
module sdtp_regs_assertions #(
    parameter logic [15:0] PART_ID    = 16'h5a5a,
    parameter logic [7:0]  DESIGN_REV = 8'h01
) (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_aux_sel,
    input wire logic [7:0]  i_table,
    input wire logic [7:0]  i_addr,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_nv_load,
    input wire logic [15:0] i_tx_power,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_rvalid,
    input wire logic        o_wr_blocked,
    input wire logic        o_mask_select,
    input wire logic        o_tx_power_high_trip,
    input wire logic        o_tx_power_low_trip,
    input wire logic [7:0]  o_tx_power_high_limit,
    input wire logic [7:0]  o_tx_power_low_limit
);
    wire logic rd5 = i_rd_en && !i_aux_sel && i_table == 8'h05;
    wire logic wr4 = (i_wr_en || i_nv_load) && !i_aux_sel && i_table == 8'h04;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    chk_id_hi: assert property (rd5 && i_addr == 8'hc0 |=> o_rdata == PART_ID[15:8])
        else $error("bad id high");
    chk_id_lo: assert property (rd5 && i_addr == 8'hc1 |=> o_rdata == PART_ID[7:0])
        else $error("bad id low");
    chk_rev_read: assert property (
        rd5 && i_addr == 8'hc2 |=> o_rvalid && o_rdata == DESIGN_REV) else $error("bad rev");
    chk_txh_trip: assert property (
        o_tx_power_high_trip == ($past(i_tx_power[15:8]) > $past(o_tx_power_high_limit)))
        else $error("bad high trip");
    chk_txl_trip: assert property (
        o_tx_power_low_trip == ($past(i_tx_power[15:8]) < $past(o_tx_power_low_limit)))
        else $error("bad low trip");
    chk_hi_limit: assert property (
        wr4 && i_addr == 8'hdb |=> o_tx_power_high_limit == $past(i_wdata))
        else $error("high limit not stored");
    chk_lo_limit: assert property (
        wr4 && i_addr == 8'hdc |=> o_tx_power_low_limit == $past(i_wdata))
        else $error("low limit not stored");
    chk_blk_cause: assert property (o_wr_blocked |-> $past(i_wr_en))
        else $error("stray block");
    chk_mask_copy: assert property (
        wr4 && i_addr == 8'hda |=> o_mask_select == $past(i_wdata[0]))
        else $error("mask select not stored");
    cover property (o_wr_blocked);
    cover property (o_tx_power_high_trip);
    cover property (i_nv_load);
endmodule : sdtp_regs_assertions
bind sdtp_regs sdtp_regs_assertions #(.PART_ID(PART_ID), .DESIGN_REV(DESIGN_REV)) chk_i (
    .i_clk, .i_arst_n, .i_aux_sel, .i_table, .i_addr, .i_wr_en, .i_rd_en, .i_wdata, .i_nv_load,
    .i_tx_power, .o_rdata, .o_rvalid, .o_wr_blocked, .o_mask_select, .o_tx_power_high_trip,
    .o_tx_power_low_trip, .o_tx_power_high_limit, .o_tx_power_low_limit);
`default_nettype wire

// >>> verification/sdtp_host.sv
// Host model that drives register requests into the slice
`timescale 1ns/100ps
`default_nettype none
module sdtp_host (
    input wire logic    i_clk,
    output logic        o_aux_sel,
    output logic [7:0]  o_table,
    output logic [7:0]  o_addr,
    output logic [7:0]  o_wdata,
    output logic        o_wr_en,
    output logic        o_rd_en,
    output logic        o_nv_load,
    output logic [31:0] o_password
);
    initial {o_aux_sel, o_table, o_addr, o_wdata, o_wr_en, o_rd_en, o_nv_load, o_password} = '0;
    // Kind 0 writes, 1 reads, 2 loads; address and data are driven inverted after release
    task automatic access(input logic a, input logic [7:0] t, ad, d, input logic [1:0] k);
        @(negedge i_clk);
        {o_aux_sel, o_table, o_addr, o_wdata} = {a, t, ad, d};
        {o_wr_en, o_rd_en, o_nv_load} = {k == 2'h0, k == 2'h1, k == 2'h2};
        @(negedge i_clk);
        {o_wr_en, o_rd_en, o_nv_load} = 3'h0;
        o_addr = ~ad;
        o_wdata = ~d;
    endtask : access
    task automatic present(input logic [31:0] pw);
        o_password = pw;
    endtask : present
    task automatic set_pw(input logic [31:0] pw);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, 8'h05, 8'hd3 + 8'(i), pw[31 - 8 * i -: 8], 2'h0);
        end
    endtask : set_pw
endmodule : sdtp_host
`default_nettype wire

// >>> verification/sdtp_regs_tb_top.sv
// Testbench for the shutdown/threshold/protect register slice
`timescale 1ns/100ps
`default_nettype none
module sdtp_regs_tb_top;
    localparam logic [15:0] PID = 16'h3c96; // Arbitrary value
    localparam logic [7:0]  REV = 8'h2b;    // Arbitrary value
    localparam logic [16:0] PIN [8] = '{17'h10000, 17'h10080, 17'h0037a, 17'h00180,
                                        17'h001ff, 17'h004c7, 17'h005f8, 17'h005d0};
    localparam logic [16:0] POUT [8] = '{17'h10080, 17'h1007f, 17'h0037b, 17'h001f8,
                                         17'h001f7, 17'h004c8, 17'h005f7, 17'h005d7};
    logic        i_clk = 1'b0, i_arst_n = 1'b0, i_bias_high_trip = 1'b0;
    logic [15:0] i_tx_power = 16'h6000, i_rssi = 16'h8000;
    logic        i_aux_sel, i_wr_en, i_rd_en, i_nv_load, o_rvalid, o_wr_blocked;
    logic        o_laser_off_drive, o_mask_select, o_tx_power_high_trip, o_tx_power_low_trip;
    logic        o_rx_loss_trip;
    logic [7:0]  i_table, i_addr, i_wdata, o_rdata, o_tx_power_high_limit;
    logic [7:0]  o_tx_power_low_limit, o_rx_loss_limit;
    logic [31:0] i_entered_password;
    int          num_errors = 0, comparisons = 0;
    always #20 i_clk = ~i_clk;
    sdtp_regs #(.PART_ID(PID), .DESIGN_REV(REV)) dut (.i_clk, .i_arst_n, .i_aux_sel, .i_table,
        .i_addr, .i_wr_en, .i_rd_en, .i_wdata, .i_entered_password, .i_nv_load, .i_tx_power,
        .i_rssi, .i_bias_high_trip, .o_rdata, .o_rvalid, .o_wr_blocked, .o_laser_off_drive,
        .o_mask_select, .o_tx_power_high_trip, .o_tx_power_low_trip, .o_rx_loss_trip,
        .o_tx_power_high_limit, .o_tx_power_low_limit, .o_rx_loss_limit);
    sdtp_host host (.i_clk, .o_aux_sel(i_aux_sel), .o_table(i_table), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_nv_load(i_nv_load),
        .o_password(i_entered_password));
    task automatic chk(input logic [7:0] g, e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("BAD at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] t, ad, e);
        host.access(1'b0, t, ad, 8'h00, 2'h1);
        chk({7'h0, o_rvalid}, 8'h01);
        chk(o_rdata, e);
    endtask : rd
    task automatic wr(input logic [16:0] p, input logic [7:0] d, input logic b);
        host.access(p[16], p[15:8], p[7:0], d, 2'h0);
        chk({7'h0, o_wr_blocked}, {7'h0, b});
    endtask : wr
    // Cause 0 power high, 1 bias high, 2 power low, other none
    task automatic cause(input int c, input logic e);
        @(negedge i_clk);
        i_tx_power = c == 0 ? 16'h90ff : (c == 2 ? 16'h2000 : 16'h6000);
        i_bias_high_trip = c == 1;
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_laser_off_drive}, {7'h0, e});
    endtask : cause
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_arst_n = 1'b1;
        chk({7'h0, o_laser_off_drive}, 8'h01);
        rd(8'h04, 8'hdb, 8'hff);
        rd(8'h04, 8'hdc, 8'h00);
        rd(8'h04, 8'hdd, 8'h00);
        rd(8'h04, 8'hda, 8'h00);
        rd(8'h05, 8'hd1, 8'h00);
        rd(8'h05, 8'hc1, PID[7:0]);
        rd(8'h05, 8'hc2, REV);
        wr(17'h005c0, 8'h55, 1'b0);
        rd(8'h05, 8'hc0, PID[15:8]);
        host.access(1'b0, 8'h04, 8'hdb, 8'h80, 2'h2);
        rd(8'h04, 8'hdb, 8'h80);
        wr(17'h004dc, 8'h40, 1'b0);
        wr(17'h004dd, 8'h20, 1'b0);
        for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 3; e++) begin
                wr(17'h004da, {p[0], 3'(4 >> e), 4'h0}, 1'b0);
                cause(e, p[0]);
                cause((e + 1) % 3, ~p[0]);
            end
        end
        cause(0, 1'b0);
        chk({7'h0, o_tx_power_high_trip}, 8'h01);
        cause(2, 1'b1);
        chk({7'h0, o_tx_power_low_trip}, 8'h01);
        for (int k = 0; k < 2; k++) begin
            @(negedge i_clk);
            i_rssi = k ? 16'h2000 : 16'h1fff;
            repeat (2) @(negedge i_clk);
            chk({7'h0, o_rx_loss_trip}, 8'(1 - k));
        end
        wr(17'h004da, 8'h8f, 1'b0);
        cause(1, 1'b0);
        chk({7'h0, o_mask_select}, 8'h01);
        rd(8'h04, 8'hda, 8'h8f);
        wr(17'h004da, 8'h00, 1'b0);
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_mask_select}, 8'h00);
        host.set_pw(32'h1234abcd);
        for (int b = 0; b < 8; b++) begin
            host.present(32'h1234abcd);
            wr(17'h005d1, 8'h01 << b, 1'b0);
            host.present(32'h0000_0000);
            wr(PIN[b], 8'h5a, 1'b1);
            wr(POUT[b], 8'h5a, 1'b0);
            host.present(32'h1234abcd);
            wr(PIN[b], 8'h5a, 1'b0);
        end
        host.present(32'h0000_0000);
        wr(17'h005d1, 8'h00, 1'b1);
        rd(8'h05, 8'hd1, 8'h80);
        host.access(1'b0, 8'h05, 8'hd1, 8'h00, 2'h2);
        rd(8'h05, 8'hd1, 8'h00);
        wrap_up();
    end
endmodule : sdtp_regs_tb_top
`default_nettype wire
